// ===== common/usbbm_defs.vh
`ifndef USBBM_DEFS_VH
`define USBBM_DEFS_VH

// ------------------------------------------------------------
// register regions, selected by address bits
// ------------------------------------------------------------
`define USBBM_CFG_RGN  6'h00
`define USBBM_STS_RGN  6'h01
`define USBBM_EVT_ADDR 12'h080
`define USBBM_FRM_ADDR 12'h084
`define USBBM_DMA_RGN  8'h0a
`define USBBM_MEM_RGN  2'h1

// ------------------------------------------------------------
// endpoint configuration word fields
// ------------------------------------------------------------
`define USBBM_CFG_EN    0
`define USBBM_CFG_ISO   1
`define USBBM_CFG_DBUF  2
`define USBBM_CFG_STALL 3
`define USBBM_CFG_TOG   4
`define USBBM_CFG_OVF   5
`define USBBM_CFG_BPS   7:6
`define USBBM_CFG_XBASE 15:8
`define USBBM_CFG_YBASE 23:16
`define USBBM_CFG_SIZE  31:24
`define USBBM_CFG_RST   32'h0000_0000

// ------------------------------------------------------------
// endpoint status word fields
// ------------------------------------------------------------
`define USBBM_STS_XCNT  7:0
`define USBBM_STS_YCNT  15:8
`define USBBM_STS_XNR   16
`define USBBM_STS_YNR   17
`define USBBM_STS_RST   18'h0_0000

// ------------------------------------------------------------
// dma channel word and handshake codes
// ------------------------------------------------------------
`define USBBM_DMA_EN    0
`define USBBM_DMA_EP    3:1
`define USBBM_HS_ACK    2'h0
`define USBBM_HS_NAK    2'h1
`define USBBM_HS_STALL  2'h2

`endif

// ===== rtl/usbbm_dma.v
`timescale 1ns/1ps
`include "usbbm_defs.vh"

module usbbm_dma (
   input  wire        clk_i,     // clock
   input  wire        rst_i,     // sync reset
   input  wire        en_i,      // channel enabled
   input  wire        sof_i,     // frame start pulse
   input  wire        sel_y_i,   // consumer buffer is y
   input  wire        nr_x_i,    // x buffer holds packet
   input  wire        nr_y_i,    // y buffer holds packet
   input  wire [7:0]  cnt_x_i,   // x sample count
   input  wire [7:0]  cnt_y_i,   // y sample count
   input  wire [7:0]  base_x_i,  // x base
   input  wire [7:0]  base_y_i,  // y base
   input  wire [1:0]  bps_i,     // bytes per sample minus one
   input  wire [7:0]  rd_data_i, // buffer byte at rd_addr_o
   output wire [7:0]  rd_addr_o, // buffer read address
   output wire        clr_o,     // clear not-ready pulse
   output wire        clr_y_o,   // cleared buffer is y
   output wire        cv_o,      // codec byte valid
   output wire [7:0]  cb_o,      // codec byte
   input  wire        cr_i       // codec ready
);

   reg        busy_q;
   reg        clr_q;
   reg        clr_y_q;
   reg        cv_q;
   reg [7:0]  cb_q;
   reg [7:0]  addr_q;
   reg [10:0] left_q;

   wire        nr_sel  = sel_y_i ? nr_y_i : nr_x_i;
   wire [7:0]  cnt_sel = sel_y_i ? cnt_y_i : cnt_x_i;
   wire [10:0] total   = cnt_sel * ({1'b0, bps_i} + 3'h1);

   always @(posedge clk_i) begin
      if (rst_i) begin
         busy_q  <= 1'b0;
         clr_q   <= 1'b0;
         clr_y_q <= 1'b0;
         cv_q    <= 1'b0;
         cb_q    <= 8'h00;
         addr_q  <= 8'h00;
         left_q  <= 11'h000;
      end else begin
         clr_q <= 1'b0;
         if (!busy_q) begin
            if (en_i && sof_i && nr_sel) begin
               clr_q   <= 1'b1;
               clr_y_q <= sel_y_i;
               addr_q  <= sel_y_i ? base_y_i : base_x_i;
               left_q  <= total;
               busy_q  <= 1'b1;
            end
         end else if (!cv_q || cr_i) begin
            if (left_q != 11'h000) begin
               cv_q   <= 1'b1;
               cb_q   <= rd_data_i;
               addr_q <= addr_q + 8'h01;
               left_q <= left_q - 11'h001;
            end else begin
               cv_q   <= 1'b0;
               busy_q <= 1'b0;
            end
         end
      end
   end

   assign rd_addr_o = addr_q;
   assign clr_o     = clr_q;
   assign clr_y_o   = clr_y_q;
   assign cv_o      = cv_q;
   assign cb_o      = cb_q;

endmodule // usbbm_dma

// ===== rtl/usbbm_top.v
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "usbbm_defs.vh"

module usbbm_top #(
   parameter NCH = 4                  // dma channels
) (
   input  wire           clk_i,       // clock
   input  wire           rst_i,       // sync reset
   input  wire           wb_cyc_i,    // wishbone cycle
   input  wire           wb_stb_i,    // wishbone strobe
   input  wire           wb_we_i,     // wishbone write
   input  wire [11:0]    wb_adr_i,    // wishbone byte address
   input  wire [31:0]    wb_dat_i,    // wishbone write data
   input  wire [3:0]     wb_sel_i,    // wishbone byte lanes
   output wire [31:0]    wb_dat_o,    // wishbone read data
   output wire           wb_ack_o,    // wishbone ack
   input  wire           tok_valid_i, // token pulse
   input  wire           tok_in_i,    // token is in
   input  wire [2:0]     tok_ep_i,    // token endpoint
   input  wire           rx_valid_i,  // out data byte strobe
   input  wire [7:0]     rx_byte_i,   // out data byte
   input  wire           rx_end_i,    // out packet end pulse
   input  wire           rx_err_i,    // crc or stuff error at end
   output wire           tx_valid_o,  // in data byte valid
   output wire [7:0]     tx_byte_o,   // in data byte
   output wire           tx_last_o,   // last beat of packet
   output wire           tx_null_o,   // beat is a zero length packet
   input  wire           tx_ready_i,  // in data taken
   input  wire           host_ack_i,  // host acked in packet
   input  wire           host_none_i, // host gave no handshake
   output wire           hs_valid_o,  // handshake pulse
   output wire [1:0]     hs_pid_o,    // handshake code
   input  wire           sof_i,       // frame start pulse
   input  wire [10:0]    frame_i,     // frame number with sof_i
   output wire [15:0]    ep_evt_o,    // pending endpoint events
   output wire [NCH-1:0] codec_valid_o, // codec byte valid per channel
   output wire [NCH*8-1:0] codec_byte_o, // codec bytes per channel
   input  wire [NCH-1:0] codec_ready_i  // codec ready per channel
);

   localparam ST_IDLE = 2'h0;
   localparam ST_RX   = 2'h1;
   localparam ST_TX   = 2'h2;
   localparam ST_WAIT = 2'h3;

   reg [31:0] cfg_q [0:15];
   reg [17:0] sts_q [0:15];
   reg [3:0]  dcfg_q [0:NCH-1];
   reg [7:0]  mem [0:255];
   reg [15:0] evt_q;
   reg [10:0] frm_q;
   reg [1:0]  st_q;
   reg [3:0]  ep_q;
   reg        bsel_q;
   reg        busy_q;
   reg [7:0]  base_q;
   reg [7:0]  ptr_q;
   reg [7:0]  cnt_q;
   reg [7:0]  smp_q;
   reg [1:0]  sub_q;
   reg        ovf_q;
   reg        hs_valid_q;
   reg [1:0]  hs_pid_q;
   reg        tx_valid_q;
   reg [7:0]  tx_byte_q;
   reg        tx_last_q;
   reg        tx_null_q;
   reg        ack_q;
   reg [31:0] rd_q;
   reg [31:0] rd_d;
   integer    i;

   function [31:0] bmerge(input [31:0] o, input [31:0] n, input [3:0] s);
      bmerge = {s[3] ? n[31:24] : o[31:24], s[2] ? n[23:16] : o[23:16],
                s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
   endfunction

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire        hit_cfg = wb_adr_i[11:6] == `USBBM_CFG_RGN;
   wire        hit_sts = wb_adr_i[11:6] == `USBBM_STS_RGN;
   wire        hit_evt = wb_adr_i == `USBBM_EVT_ADDR;
   wire        hit_frm = wb_adr_i == `USBBM_FRM_ADDR;
   wire        hit_dma = wb_adr_i[11:4] == `USBBM_DMA_RGN;
   wire        hit_mem = wb_adr_i[11:10] == `USBBM_MEM_RGN;
   wire [3:0]  widx    = wb_adr_i[5:2];
   wire [31:0] m_cfg   = bmerge(cfg_q[widx], wb_dat_i, wb_sel_i);
   wire [31:0] m_sts   = bmerge({14'h0000, sts_q[widx]}, wb_dat_i, wb_sel_i);

   // ------------------------------------------------------------
   // endpoint views
   // ------------------------------------------------------------
   wire [3:0]  tix   = {tok_in_i, tok_ep_i};
   wire [31:0] tcfg  = cfg_q[tix];
   wire [17:0] tsts  = sts_q[tix];
   wire [31:0] ccfg  = cfg_q[ep_q];
   wire        t_ok  = (tok_ep_i != 3'h0) && tcfg[`USBBM_CFG_EN];
   wire        osel  = tcfg[`USBBM_CFG_ISO] ? frm_q[0] :
                       (tcfg[`USBBM_CFG_DBUF] & tcfg[`USBBM_CFG_TOG]);
   wire        isel  = tcfg[`USBBM_CFG_DBUF] & tcfg[`USBBM_CFG_TOG];
   wire        c_iso = ccfg[`USBBM_CFG_ISO];
   wire        c_stl = ccfg[`USBBM_CFG_STALL];
   wire        room  = ptr_q < ccfg[`USBBM_CFG_SIZE];
   wire        rx_wr = (st_q == ST_RX) && rx_valid_i && room && (!busy_q || c_iso) && !c_stl;
   wire        wb_go = wb_cyc_i && wb_stb_i && !ack_q && !(hit_mem && wb_we_i && rx_wr);

   // ------------------------------------------------------------
   // dma channels
   // ------------------------------------------------------------
   wire [NCH-1:0]   dclr;
   wire [NCH-1:0]   dclr_y;
   wire [NCH*8-1:0] daddr;

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_dma
         wire [3:0]  dep = {1'b0, dcfg_q[g][`USBBM_DMA_EP]};
         wire [31:0] dc  = cfg_q[dep];
         wire [17:0] ds  = sts_q[dep];
         usbbm_dma u_dma (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .en_i      (dcfg_q[g][`USBBM_DMA_EN] & dc[`USBBM_CFG_ISO]),
            .sof_i     (sof_i),
            .sel_y_i   (~frame_i[0]),
            .nr_x_i    (ds[`USBBM_STS_XNR]),
            .nr_y_i    (ds[`USBBM_STS_YNR]),
            .cnt_x_i   (ds[`USBBM_STS_XCNT]),
            .cnt_y_i   (ds[`USBBM_STS_YCNT]),
            .base_x_i  (dc[`USBBM_CFG_XBASE]),
            .base_y_i  (dc[`USBBM_CFG_YBASE]),
            .bps_i     (dc[`USBBM_CFG_BPS]),
            .rd_data_i (mem[daddr[g*8 +: 8]]),
            .rd_addr_o (daddr[g*8 +: 8]),
            .clr_o     (dclr[g]),
            .clr_y_o   (dclr_y[g]),
            .cv_o      (codec_valid_o[g]),
            .cb_o      (codec_byte_o[g*8 +: 8]),
            .cr_i      (codec_ready_i[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // buffer memory write port
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rx_wr) begin
         mem[base_q + ptr_q] <= rx_byte_i;
      end else if (wb_go && wb_we_i && hit_mem && wb_sel_i[0]) begin
         mem[wb_adr_i[9:2]] <= wb_dat_i[7:0];
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always @* begin
      rd_d = 32'h0000_0000;
      if (hit_cfg) begin
         rd_d = cfg_q[widx];
      end else if (hit_sts) begin
         rd_d = {14'h0000, sts_q[widx]};
      end else if (hit_evt) begin
         rd_d = {16'h0000, evt_q};
      end else if (hit_frm) begin
         rd_d = {21'h00_0000, frm_q};
      end else if (hit_dma && wb_adr_i[3:2] < NCH) begin
         rd_d = {28'h000_0000, dcfg_q[wb_adr_i[3:2]]};
      end else if (hit_mem) begin
         rd_d = {24'h00_0000, mem[wb_adr_i[9:2]]};
      end
   end

   // ------------------------------------------------------------
   // registers and transaction engine
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (i = 0; i < 16; i = i + 1) begin
            cfg_q[i] <= `USBBM_CFG_RST;
            sts_q[i] <= `USBBM_STS_RST;
         end
         for (i = 0; i < NCH; i = i + 1) begin
            dcfg_q[i] <= 4'h0;
         end
         evt_q      <= 16'h0000;
         frm_q      <= 11'h000;
         st_q       <= ST_IDLE;
         ep_q       <= 4'h0;
         bsel_q     <= 1'b0;
         busy_q     <= 1'b0;
         base_q     <= 8'h00;
         ptr_q      <= 8'h00;
         cnt_q      <= 8'h00;
         smp_q      <= 8'h00;
         sub_q      <= 2'h0;
         ovf_q      <= 1'b0;
         hs_valid_q <= 1'b0;
         hs_pid_q   <= `USBBM_HS_ACK;
         tx_valid_q <= 1'b0;
         tx_byte_q  <= 8'h00;
         tx_last_q  <= 1'b0;
         tx_null_q  <= 1'b0;
         ack_q      <= 1'b0;
         rd_q       <= 32'h0000_0000;
      end else begin
         ack_q      <= wb_go;
         hs_valid_q <= 1'b0;
         if (wb_go) begin
            rd_q <= rd_d;
         end
         if (sof_i) begin
            frm_q <= frame_i;
         end
         // software writes first, hardware updates below win
         if (wb_go && wb_we_i) begin
            if (hit_cfg) begin
               cfg_q[widx] <= m_cfg;
            end
            if (hit_sts) begin
               sts_q[widx] <= m_sts[17:0];
            end
            if (hit_evt) begin
               evt_q <= evt_q & ~{wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
            end
            if (hit_dma && wb_adr_i[3:2] < NCH && wb_sel_i[0]) begin
               dcfg_q[wb_adr_i[3:2]] <= wb_dat_i[3:0];
            end
         end
         for (i = 0; i < NCH; i = i + 1) begin
            if (dclr[i]) begin
               if (dclr_y[i]) begin
                  sts_q[{1'b0, dcfg_q[i][`USBBM_DMA_EP]}][`USBBM_STS_YNR] <= 1'b0;
               end else begin
                  sts_q[{1'b0, dcfg_q[i][`USBBM_DMA_EP]}][`USBBM_STS_XNR] <= 1'b0;
               end
            end
         end
         case (st_q)
            ST_IDLE: begin
               if (tok_valid_i && t_ok) begin
                  ep_q  <= tix;
                  ptr_q <= 8'h00;
                  if (!tok_in_i) begin
                     st_q   <= ST_RX;
                     bsel_q <= osel;
                     busy_q <= osel ? tsts[`USBBM_STS_YNR] : tsts[`USBBM_STS_XNR];
                     base_q <= osel ? tcfg[`USBBM_CFG_YBASE] : tcfg[`USBBM_CFG_XBASE];
                     smp_q  <= 8'h00;
                     sub_q  <= 2'h0;
                     ovf_q  <= 1'b0;
                  end else if (tcfg[`USBBM_CFG_STALL]) begin
                     hs_valid_q <= 1'b1;
                     hs_pid_q   <= `USBBM_HS_STALL;
                  end else if (!tcfg[`USBBM_CFG_ISO]) begin
                     bsel_q <= isel;
                     if (isel ? tsts[`USBBM_STS_YNR] : tsts[`USBBM_STS_XNR]) begin
                        hs_valid_q <= 1'b1;
                        hs_pid_q   <= `USBBM_HS_NAK;
                     end else begin
                        st_q   <= ST_TX;
                        base_q <= isel ? tcfg[`USBBM_CFG_YBASE] : tcfg[`USBBM_CFG_XBASE];
                        cnt_q  <= isel ? tsts[`USBBM_STS_YCNT] : tsts[`USBBM_STS_XCNT];
                     end
                  end
               end
            end
            ST_RX: begin
               if (rx_valid_i) begin
                  if (room) begin
                     ptr_q <= ptr_q + 8'h01;
                     if (sub_q == ccfg[`USBBM_CFG_BPS]) begin
                        sub_q <= 2'h0;
                        smp_q <= smp_q + 8'h01;
                     end else begin
                        sub_q <= sub_q + 2'h1;
                     end
                  end else begin
                     ovf_q <= 1'b1;
                  end
               end
               if (rx_end_i) begin
                  st_q <= ST_IDLE;
                  if (rx_err_i) begin
                     st_q <= ST_IDLE;
                  end else if (c_stl) begin
                     hs_valid_q <= 1'b1;
                     hs_pid_q   <= `USBBM_HS_STALL;
                  end else if (c_iso) begin
                     if (bsel_q) begin
                        sts_q[ep_q][`USBBM_STS_YCNT] <= smp_q;
                        sts_q[ep_q][`USBBM_STS_YNR]  <= 1'b1;
                     end else begin
                        sts_q[ep_q][`USBBM_STS_XCNT] <= smp_q;
                        sts_q[ep_q][`USBBM_STS_XNR]  <= 1'b1;
                     end
                     if (ovf_q) begin
                        cfg_q[ep_q][`USBBM_CFG_OVF] <= 1'b1;
                     end
                  end else if (busy_q) begin
                     hs_valid_q <= 1'b1;
                     hs_pid_q   <= `USBBM_HS_NAK;
                  end else begin
                     hs_valid_q <= 1'b1;
                     hs_pid_q   <= `USBBM_HS_ACK;
                     cfg_q[ep_q][`USBBM_CFG_TOG] <= ~ccfg[`USBBM_CFG_TOG];
                     evt_q[ep_q] <= 1'b1;
                     if (bsel_q) begin
                        sts_q[ep_q][`USBBM_STS_YCNT] <= ptr_q;
                        sts_q[ep_q][`USBBM_STS_YNR]  <= 1'b1;
                     end else begin
                        sts_q[ep_q][`USBBM_STS_XCNT] <= ptr_q;
                        sts_q[ep_q][`USBBM_STS_XNR]  <= 1'b1;
                     end
                  end
               end
            end
            ST_TX: begin
               if (tx_valid_q && tx_ready_i && tx_last_q) begin
                  tx_valid_q <= 1'b0;
                  tx_last_q  <= 1'b0;
                  tx_null_q  <= 1'b0;
                  st_q       <= ST_WAIT;
               end else if (!tx_valid_q || tx_ready_i) begin
                  tx_valid_q <= 1'b1;
                  tx_byte_q  <= mem[base_q + ptr_q];
                  tx_null_q  <= cnt_q == 8'h00;
                  tx_last_q  <= (cnt_q == 8'h00) || (ptr_q + 8'h01 == cnt_q);
                  ptr_q      <= ptr_q + 8'h01;
               end
            end
            ST_WAIT: begin
               if (host_ack_i) begin
                  st_q <= ST_IDLE;
                  cfg_q[ep_q][`USBBM_CFG_TOG] <= ~ccfg[`USBBM_CFG_TOG];
                  evt_q[ep_q] <= 1'b1;
                  if (bsel_q) begin
                     sts_q[ep_q][`USBBM_STS_YNR] <= 1'b1;
                  end else begin
                     sts_q[ep_q][`USBBM_STS_XNR] <= 1'b1;
                  end
               end else if (host_none_i) begin
                  st_q <= ST_IDLE;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   assign wb_dat_o   = rd_q;
   assign wb_ack_o   = ack_q;
   assign tx_valid_o = tx_valid_q;
   assign tx_byte_o  = tx_byte_q;
   assign tx_last_o  = tx_last_q;
   assign tx_null_o  = tx_null_q;
   assign hs_valid_o = hs_valid_q;
   assign hs_pid_o   = hs_pid_q;
   assign ep_evt_o   = evt_q;

endmodule // usbbm_top

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(n,e,s) begin compares++; if ((e) !== (s)) begin failures++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top;
   reg         clk_i = 0, rst_i = 1, cyc = 0, we = 0, tv = 0, ti = 0, rv = 0, re = 0, rr = 0, sof = 0, mode = 0;
   reg  [11:0] adr = 0;
   reg  [31:0] wd = 0, rdat;
   reg  [2:0]  tep = 0, hs = 4;
   reg  [7:0]  rb = 0, cbeats = 0, cbyte = 0;
   reg         nul = 0;
   wire [3:0]  cvl;
   wire [31:0] cbb;
   wire        txn;
   reg  [10:0] frm = 0;
   wire [31:0] dat_o;
   wire        ack, txv, txl, txr, hak, hno, hsv;
   wire [7:0]  txb, beats, lastb;
   wire [1:0]  pid;
   wire [15:0] evt;
   integer     failures = 0, compares = 0, i;
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) hs <= hsv ? {1'b0, pid} : (tv ? 3'h4 : hs);
   always @(posedge clk_i) if (txv && txr && txl) nul <= txn;
   always @(posedge clk_i) if (cvl[0]) begin cbeats <= cbeats + 8'h1; cbyte <= cbb[7:0]; end
   usbbm_top dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd),
      .wb_sel_i(4'hf), .wb_dat_o(dat_o), .wb_ack_o(ack), .tok_valid_i(tv), .tok_in_i(ti), .tok_ep_i(tep),
      .rx_valid_i(rv), .rx_byte_i(rb), .rx_end_i(re), .rx_err_i(rr), .tx_valid_o(txv), .tx_byte_o(txb),
      .tx_last_o(txl), .tx_null_o(txn), .tx_ready_i(txr), .host_ack_i(hak), .host_none_i(hno), .hs_valid_o(hsv),
      .hs_pid_o(pid), .sof_i(sof), .frame_i(frm), .ep_evt_o(evt), .codec_valid_o(cvl), .codec_byte_o(cbb),
      .codec_ready_i(4'hf));
   usbbm_host_model host_u (.clk_i, .rst_i, .tx_valid_i(txv), .tx_byte_i(txb), .tx_last_i(txl), .ack_mode_i(mode),
      .tx_ready_o(txr), .host_ack_o(hak), .host_none_o(hno), .beats_o(beats), .byte_o(lastb));
   // ----------------------------------------
   // bus and usb tasks
   // ----------------------------------------
   task give_verdict;
      begin
         $display("compares %0d failures %0d", compares, failures);
         if (failures == 0 && compares > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   task wb(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         cyc <= 1; we <= w; adr <= a; wd <= d; n = 0;
         do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
         if (ack !== 1'b1) begin failures++; give_verdict; end
         rdat = dat_o;
         cyc <= 0;
         @(posedge clk_i);
      end
   endtask
   task rd(input [11:0] a, input [31:0] e);
      begin wb(0, a, 32'h0); `CHK("register", e, rdat) end
   endtask
   task pkt(input [2:0] ep, input integer n, input err, input [2:0] e);
      begin
         tv <= 1; ti <= 0; tep <= ep;
         @(posedge clk_i);
         tv <= 0;
         for (i = 0; i < n; i++) begin rv <= 1; rb <= 8'ha0 + i[7:0]; @(posedge clk_i); end
         rv <= 0; re <= 1; rr <= err;
         @(posedge clk_i);
         re <= 0; rr <= 0;
         repeat (3) @(posedge clk_i);
         `CHK("handshake", e, hs)
      end
   endtask
   task tok_in(input [2:0] e);
      begin
         tv <= 1; ti <= 1; tep <= 3'h1;
         @(posedge clk_i);
         tv <= 0;
         repeat (16) @(posedge clk_i);
         `CHK("handshake", e, hs)
      end
   endtask
   task sofp(input [10:0] f);
      begin
         frm <= f; sof <= 1;
         @(posedge clk_i);
         sof <= 0;
         repeat (12) @(posedge clk_i);
      end
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      rd(12'h004, 32'h0);
      wb(1, 12'h004, 32'h0800_1001);
      pkt(3'h1, 3, 0, 3'h0);
      rd(12'h044, 32'h0001_0003);
      rd(12'h004, 32'h0800_1011);
      rd(12'h080, 32'h2);
      rd(12'h448, 32'ha2);
      pkt(3'h1, 2, 0, 3'h1);
      rd(12'h044, 32'h0001_0003);
      pkt(3'h1, 2, 1, 3'h4);
      wb(1, 12'h080, 32'h2);
      wb(1, 12'h044, 32'h0);
      rd(12'h080, 32'h0);
      wb(1, 12'h004, 32'h0830_1015);
      pkt(3'h1, 1, 0, 3'h0);
      rd(12'h044, 32'h0002_0100);
      rd(12'h004, 32'h0830_1005);
      rd(12'h4c0, 32'ha0);
      wb(1, 12'h004, 32'h0800_1009);
      pkt(3'h1, 1, 0, 3'h2);
      pkt(3'h0, 1, 0, 3'h4);
      wb(1, 12'h024, 32'h0800_2001);
      wb(1, 12'h064, 32'h0001_0000);
      wb(1, 12'h480, 32'h55);
      wb(1, 12'h484, 32'h66);
      wb(1, 12'h064, 32'h2);
      tok_in(3'h4);
      `CHK("beats", 8'h2, beats)
      `CHK("byte", 8'h66, lastb)
      rd(12'h024, 32'h0800_2001);
      mode <= 1;
      tok_in(3'h4);
      `CHK("beats", 8'h4, beats)
      rd(12'h024, 32'h0800_2011);
      rd(12'h064, 32'h0001_0002);
      rd(12'h080, 32'h202);
      tok_in(3'h1);
      wb(1, 12'h064, 32'h0);
      tok_in(3'h4);
      `CHK("null", 1'b1, nul)
      wb(1, 12'h008, 32'h0850_4043);
      sofp(11'h1);
      pkt(3'h2, 4, 0, 3'h4);
      rd(12'h048, 32'h0002_0200);
      sofp(11'h0);
      rd(12'h084, 32'h0);
      rd(12'h048, 32'h0002_0200);
      wb(1, 12'h048, 32'h0);
      rd(12'h540, 32'ha0);
      pkt(3'h2, 9, 0, 3'h4);
      rd(12'h008, 32'h0850_4063);
      rd(12'h048, 32'h0001_0004);
      wb(1, 12'h0a0, 32'h5);
      sofp(11'h1);
      `CHK("codec beats", 8'h8, cbeats)
      `CHK("codec byte", 8'ha7, cbyte)
      rd(12'h048, 32'h0000_0004);
      sofp(11'h1);
      `CHK("codec beats", 8'h8, cbeats)
      rd(12'h080, 32'h202);
      give_verdict;
   end
endmodule // tb_top

// ===== tb/usbbm_checker.sv
`timescale 1ns/1ps
module usbbm_checker (
   input wire        clk_i,       // clock
   input wire        rst_i,       // reset
   input wire        wb_cyc_i,    // cycle
   input wire        wb_stb_i,    // strobe
   input wire        wb_ack_o,    // ack
   input wire        tok_valid_i, // token
   input wire        tok_in_i,    // in token
   input wire [2:0]  tok_ep_i,    // endpoint
   input wire        rx_end_i,    // packet end
   input wire        rx_err_i,    // packet error
   input wire        tx_valid_o,  // in byte valid
   input wire [7:0]  tx_byte_o,   // in byte
   input wire        tx_ready_i,  // sink ready
   input wire        hs_valid_o,  // handshake
   input wire        host_ack_i,  // host ack
   input wire [15:0] ep_evt_o     // events
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_bad_end;
      rx_end_i && rx_err_i;
   endsequence
   sequence s_tx_wait;
      tx_valid_o && !tx_ready_i;
   endsequence
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   chk_hs_pulse: assert property (hs_valid_o |=> !hs_valid_o) else $error("handshake longer than one cycle");
   chk_hs_cause: assert property (hs_valid_o |-> $past(rx_end_i) || $past(tok_valid_i && tok_in_i))
      else $error("handshake without packet end or in token");
   chk_err_silent: assert property (s_bad_end |=> !hs_valid_o) else $error("handshake after bad packet");
   chk_tx_hold: assert property (s_tx_wait |=> tx_valid_o && $stable(tx_byte_o)) else $error("in byte not held");
   chk_ep_zero: assert property (tok_valid_i && tok_ep_i == 3'h0 && !tx_valid_o |=> !tx_valid_o [*2])
      else $error("endpoint zero answered");
   chk_evt_cause: assert property (|(ep_evt_o & ~$past(ep_evt_o)) |-> $past(host_ack_i || rx_end_i))
      else $error("event without transaction");
endmodule // usbbm_checker
bind usbbm_top usbbm_checker chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tok_valid_i, .tok_in_i,
   .tok_ep_i, .rx_end_i, .rx_err_i, .tx_valid_o, .tx_byte_o, .tx_ready_i, .hs_valid_o, .host_ack_i, .ep_evt_o);

// ===== tb/usbbm_host_model.sv
`timescale 1ns/1ps
module usbbm_host_model (
   input  wire       clk_i,       // clock
   input  wire       rst_i,       // reset
   input  wire       tx_valid_i,  // in byte valid
   input  wire [7:0] tx_byte_i,   // in byte
   input  wire       tx_last_i,   // last beat
   input  wire       ack_mode_i,  // 1 ack, 0 silent
   output reg        tx_ready_o,  // slow sink
   output reg        host_ack_o,  // ack pulse
   output reg        host_none_o, // timeout pulse
   output reg  [7:0] beats_o,     // beats taken
   output reg  [7:0] byte_o       // last byte taken
);
   always @(posedge clk_i) begin
      if (rst_i) begin
         {tx_ready_o, host_ack_o, host_none_o, beats_o, byte_o} <= 19'h0;
      end else begin
         tx_ready_o  <= ~tx_ready_o;
         host_ack_o  <= 1'b0;
         host_none_o <= 1'b0;
         if (tx_valid_i && tx_ready_o) begin
            beats_o <= beats_o + 8'h1;
            byte_o  <= tx_byte_i;
            host_ack_o  <= tx_last_i && ack_mode_i;
            host_none_o <= tx_last_i && !ack_mode_i;
         end
      end
   end
endmodule // usbbm_host_model
